//--- pttc_cnt8.sv
// pttc_cnt8: one 8-bit up counter with a synchronised timer clock input
// assumes timer_clock is a slow level from another clock, at most half the core rate
`timescale 1ns/1ps
module pttc_cnt8 (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // count sources
    input wire logic timer_clock,
    input wire logic run,
    input wire logic use_carry,
    input wire logic carry_in,
    input wire logic clr,
    // state and carry
    output logic [7:0] count,
    output logic carry_out
);
    logic [7:0] count_q, count_d;
    logic s1_q, s2_q, s3_q;
    logic inc;

    assign inc = use_carry ? carry_in : (run && s2_q && !s3_q);
    assign carry_out = inc && (count_q == 8'hFF) && !clr;
    assign count = count_q;

    always_comb begin
        count_d = count_q;
        if (clr) begin
            count_d = pttc_pkg::CNT_RST;
        end else if (inc) begin
            count_d = count_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= pttc_pkg::CNT_RST;
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            count_q <= count_d;
            s1_q <= timer_clock;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    AST_CLR_ZERO: assert property (@(posedge core_clk) disable iff (!resetn)
        clr |=> count_q == 8'h00)
        else $error("counter not cleared by write");
    AST_UP_COUNT: assert property (@(posedge core_clk) disable iff (!resetn)
        (inc && !clr) |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not step by one");
    AST_SYNC_EDGE: assert property (@(posedge core_clk) disable iff (!resetn)
        (!$past(use_carry) && !$past(clr) && $past(run) && count_q != $past(count_q)
            && $past(resetn, 4)) |-> $past(timer_clock, 3) && !$past(timer_clock, 4))
        else $error("count moved without a synchronised clock edge");
endmodule // pttc_cnt8

//--- pttc_pkg.sv
// pttc_pkg: register indices, field positions and encodings of the paired timer counters
// assumes AXI4-Lite with 32-bit data; byte address of a register is four times its index
package pttc_pkg;
    localparam int ADDR_W = 18;
    localparam int N_TMR = 6;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_RST = 8'h00;
    // register indices
    localparam logic [15:0] IDX_P1_LO = 16'hF8E1;
    localparam logic [15:0] IDX_P1_HI = 16'hF8E5;
    localparam logic [15:0] IDX_P2_LO = 16'hF8E9;
    localparam logic [15:0] IDX_P2_HI = 16'hF8ED;
    localparam logic [15:0] IDX_P3_LO = 16'hF361;
    localparam logic [15:0] IDX_P3_HI = 16'hF369;
    localparam logic [15:0] IDX_CTRL = 16'hF370;
    localparam logic [15:0] IDX_CLKSEL = 16'hF371;
    localparam logic [15:0] IDX_STATUS = 16'hF372;
    // decoder results
    localparam logic [3:0] DEC_CTRL = 4'h6;
    localparam logic [3:0] DEC_CLKSEL = 4'h7;
    localparam logic [3:0] DEC_STATUS = 4'h8;
    localparam logic [3:0] DEC_NONE = 4'hF;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SYSHS_BIT = 3;
    localparam int CTRL_RUN_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_3F0F;
    // clock select register: three bits per timer
    localparam int CKS_W = 3;
    localparam logic [17:0] CKS_RST = 18'h0_0000;
    localparam logic [2:0] CKS_LOW = 3'h0;
    localparam logic [2:0] CKS_HTB = 3'h1;
    localparam logic [2:0] CKS_PLL = 3'h7;
    // status register fields
    localparam int STAT_SINGLE_LSB = 0;
    localparam int STAT_READ_LSB = 8;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- pttc_top.sv
// pttc_top: six timer count registers in three pairs behind an AXI4-Lite slave
// assumes timer clocks arrive as levels; the master keeps one write and one read at a time
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
// Functional notes
// - each count register is an 8-bit up counter on its timer clock, zero after reset
// - any write clears the counter to zero; write data is ignored
// - in 16-bit mode a write to either half clears both halves
// - in 16-bit mode reading the low half latches the high half for later reads
// - reads are invalid for time-base clocks with slow system clock, and for pll clock
// - single read valid for slow/slow and undivided time-base with fast system clock
// - in 16-bit mode the high half counts low overflows; low raises no event
module pttc_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // write address and data
    input wire logic [17:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer clocks and overflow events
    input wire logic [5:0] timer_clock,
    output logic [5:0] timer_overflow
);
    // register decode: timer number, own register or none
    function automatic logic [3:0] dec(input logic [17:0] addr);
        logic [15:0] idx;
        idx = addr[17:2];
        case (idx)
            pttc_pkg::IDX_P1_LO: dec = 4'h0;
            pttc_pkg::IDX_P1_HI: dec = 4'h1;
            pttc_pkg::IDX_P2_LO: dec = 4'h2;
            pttc_pkg::IDX_P2_HI: dec = 4'h3;
            pttc_pkg::IDX_P3_LO: dec = 4'h4;
            pttc_pkg::IDX_P3_HI: dec = 4'h5;
            pttc_pkg::IDX_CTRL: dec = pttc_pkg::DEC_CTRL;
            pttc_pkg::IDX_CLKSEL: dec = pttc_pkg::DEC_CLKSEL;
            pttc_pkg::IDX_STATUS: dec = pttc_pkg::DEC_STATUS;
            default: dec = pttc_pkg::DEC_NONE;
        endcase
    endfunction

    // one read returns a settled count
    function automatic logic single_ok(input logic [2:0] cks, input logic hs);
        case (cks)
            pttc_pkg::CKS_LOW: single_ok = !hs;
            pttc_pkg::CKS_HTB: single_ok = hs;
            default: single_ok = 1'b0;
        endcase
    endfunction

    // a read may be used at all, maybe after a repeat
    function automatic logic read_ok(input logic [2:0] cks, input logic hs);
        case (cks)
            pttc_pkg::CKS_LOW: read_ok = 1'b1;
            pttc_pkg::CKS_PLL: read_ok = 1'b0;
            default: read_ok = hs;
        endcase
    endfunction

    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [17:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [17:0] cks_q, cks_d;
    logic [7:0] latch_q [3];
    logic [7:0] latch_d [3];
    logic [5:0] ovf_q, ovf_d;
    logic aw_have, w_have, wr_fire, rd_fire;
    logic [17:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [3:0] wr_dec, rd_dec;
    logic [2:0] mode16;
    logic sys_hs;
    logic [5:0] run, clr, carry, sgl, rdok;
    logic [7:0] cnt [6];

    assign mode16 = ctrl_q[pttc_pkg::CTRL_MODE_LSB +: 3];
    assign sys_hs = ctrl_q[pttc_pkg::CTRL_SYSHS_BIT];
    assign run = ctrl_q[pttc_pkg::CTRL_RUN_LSB +: 6];

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign timer_overflow = ovf_q;

    // address and data may come in either order
    assign aw_have = aw_hold_q || (s_axi_awvalid && s_axi_awready);
    assign w_have = w_hold_q || (s_axi_wvalid && s_axi_wready);
    assign wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_hold_q ? w_data_q : s_axi_wdata;
    assign wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
    assign wr_fire = aw_have && w_have && !bvalid_q;
    assign wr_dec = dec(wr_addr);
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_dec = dec(s_axi_araddr);

    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_tmr
            localparam int P = i / 2;
            localparam int LO = i - (i % 2);
            logic [2:0] eff_cks;
            logic eff_run;
            assign clr[i] = wr_fire && ((wr_dec == 4'(i))
                || (mode16[P] && (wr_dec == 4'(i ^ 1))));
            // divided clock select of the high half is meaningless when paired
            assign eff_cks = (i % 2 == 1 && mode16[P]) ? cks_q[LO*3 +: 3] : cks_q[i*3 +: 3];
            assign eff_run = (i % 2 == 1 && mode16[P]) ? run[LO] : run[i];
            assign rdok[i] = !eff_run || read_ok(eff_cks, sys_hs);
            assign sgl[i] = !eff_run || single_ok(eff_cks, sys_hs);
            pttc_cnt8 u_cnt (
                .core_clk(core_clk),
                .resetn(resetn),
                .timer_clock(timer_clock[i]),
                .run(run[i]),
                .use_carry((i % 2 == 1) && mode16[P]),
                .carry_in(carry[LO]),
                .clr(clr[i]),
                .count(cnt[i]),
                .carry_out(carry[i])
            );
        end
    endgenerate

    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        cks_d = cks_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_dec == pttc_pkg::DEC_NONE) ? pttc_pkg::RESP_SLVERR
                : pttc_pkg::RESP_OKAY;
            for (int b = 0; b < 4; b++) begin
                if (wr_strb[b] && wr_dec == pttc_pkg::DEC_CTRL) begin
                    ctrl_d[b*8 +: 8] = wr_data[b*8 +: 8] & pttc_pkg::CTRL_MASK[b*8 +: 8];
                end
            end
            if (wr_dec == pttc_pkg::DEC_CLKSEL) begin
                for (int b = 0; b < 18; b++) begin
                    if (wr_strb[b / 8]) begin
                        cks_d[b] = wr_data[b];
                    end
                end
            end
        end
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        for (int p = 0; p < 3; p++) begin
            latch_d[p] = latch_q[p];
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d = pttc_pkg::RESP_OKAY;
            rdata_d = 32'h0000_0000;
            case (rd_dec)
                4'h0, 4'h2, 4'h4: begin
                    rdata_d[7:0] = cnt[rd_dec[2:0]];
                    if (mode16[rd_dec[2:1]]) begin
                        latch_d[rd_dec[2:1]] = cnt[rd_dec[2:0] + 3'h1];
                    end
                end
                4'h1, 4'h3, 4'h5: begin
                    rdata_d[7:0] = mode16[rd_dec[2:1]] ? latch_q[rd_dec[2:1]]
                        : cnt[rd_dec[2:0]];
                end
                pttc_pkg::DEC_CTRL: rdata_d = ctrl_q;
                pttc_pkg::DEC_CLKSEL: rdata_d = {14'h0000, cks_q};
                pttc_pkg::DEC_STATUS: begin
                    rdata_d[pttc_pkg::STAT_SINGLE_LSB +: 6] = sgl;
                    rdata_d[pttc_pkg::STAT_READ_LSB +: 6] = rdok;
                end
                default: rresp_d = pttc_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_comb begin
        for (int t = 0; t < 6; t++) begin
            // paired low half raises no event
            ovf_d[t] = carry[t] && !((t % 2 == 0) && mode16[t / 2]);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 18'h0_0000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= pttc_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= pttc_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            ctrl_q <= pttc_pkg::CTRL_RST;
            cks_q <= pttc_pkg::CKS_RST;
            ovf_q <= 6'h00;
            for (int p = 0; p < 3; p++) begin
                latch_q[p] <= pttc_pkg::CNT_RST;
            end
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            cks_q <= cks_d;
            ovf_q <= ovf_d;
            for (int p = 0; p < 3; p++) begin
                latch_q[p] <= latch_d[p];
            end
        end
    end

    AST_PAIR_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
        (wr_fire && wr_dec == 4'h3 && mode16[1]) |=> (cnt[2] == 8'h00 && cnt[3] == 8'h00))
        else $error("paired write left a half uncleared");
    AST_LATCH_TAKE: assert property (@(posedge core_clk) disable iff (!resetn)
        (rd_fire && rd_dec == 4'h2 && mode16[1]) |=> latch_q[1] == $past(cnt[3]))
        else $error("high half not latched on low read");
    AST_HIGH_FROM_LATCH: assert property (@(posedge core_clk) disable iff (!resetn)
        (rd_fire && rd_dec == 4'h3 && mode16[1]) |=> s_axi_rdata[7:0] == $past(latch_q[1]))
        else $error("high read did not return latch");
    AST_PLL_INVALID: assert property (@(posedge core_clk) disable iff (!resetn)
        (run[4] && cks_q[14:12] == pttc_pkg::CKS_PLL) |-> !rdok[4] && !sgl[4])
        else $error("pll clock read marked valid");
    AST_HTB_FAST_OK: assert property (@(posedge core_clk) disable iff (!resetn)
        (run[4] && !mode16[2] && cks_q[14:12] == pttc_pkg::CKS_HTB)
        |-> (sgl[4] == sys_hs && rdok[4] == sys_hs))
        else $error("time-base read validity wrong");
    AST_LOW_NO_EVENT: assert property (@(posedge core_clk) disable iff (!resetn)
        $past(mode16[1]) |-> !timer_overflow[2])
        else $error("paired low half raised an overflow");
endmodule // pttc_top

//--- pttc_top_test.sv
// pttc_top_test: register-level bench for the paired timer count registers
// assumes an AXI4-Lite slave answering within a few cycles and slow timer clock levels
`timescale 1ns/1ps
module pttc_top_test;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [17:0] s_axi_awaddr = 18'h0_0000;
    logic [17:0] s_axi_araddr = 18'h0_0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [5:0] timer_clock = 6'h00;
    logic s_axi_awready;
    logic s_axi_wready;
    logic s_axi_bvalid;
    logic s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [5:0] timer_overflow;
    int n_fail = 0;
    int n_compared = 0;
    int ovf_cnt [6] = '{default: 0};
    logic [31:0] d;
    logic [31:0] prev;
    logic [1:0] r;
    logic single;
    logic usable;

    pttc_top dut (
        .core_clk(core_clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .timer_clock(timer_clock), .timer_overflow(timer_overflow)
    );

    always #10 core_clk = ~core_clk;

    // overflow pulses are one cycle wide, so count them at every falling edge
    always @(negedge core_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (resetn === 1'b1 && timer_overflow[i] === 1'b1) begin
                ovf_cnt[i] <= ovf_cnt[i] + 1;
            end
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [15:0] idx, input logic [31:0] dat);
        logic aw_now;
        logic w_now;
        logic done;
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        done = 1'b0;
        r = 2'h3;
        for (int n = 0; n < 100 && !done; n++) begin
            // look where the answer has settled, act after the next rising edge
            @(negedge core_clk);
            aw_now = s_axi_awvalid && s_axi_awready === 1'b1;
            w_now = s_axi_wvalid && s_axi_wready === 1'b1;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                done = 1'b1;
            end
            @(posedge core_clk);
            if (aw_now) begin
                s_axi_awvalid <= 1'b0;
            end
            if (w_now) begin
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        chk("write answered", {31'h0, done}, 32'h1);
    endtask

    task automatic axi_rd(input logic [15:0] idx);
        logic ar_now;
        logic done;
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 100 && !done; n++) begin
            @(negedge core_clk);
            ar_now = s_axi_arvalid && s_axi_arready === 1'b1;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                done = 1'b1;
            end
            @(posedge core_clk);
            if (ar_now) begin
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
        chk("read answered", {31'h0, done}, 32'h1);
    endtask

    task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        axi_rd(idx);
        chk(what, d, exp);
        chk("read response", {30'h0, r}, {30'h0, pttc_pkg::RESP_OKAY});
    endtask

    // two core cycles per timer clock period, then room for the synchroniser
    task automatic pulse(input int t, input int n);
        repeat (n) begin
            @(posedge core_clk);
            timer_clock[t] <= 1'b1;
            @(posedge core_clk);
            timer_clock[t] <= 1'b0;
        end
        repeat (5) @(posedge core_clk);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        rd_chk("pair1 low", pttc_pkg::IDX_P1_LO, 32'h0);
        rd_chk("pair1 high", pttc_pkg::IDX_P1_HI, 32'h0);
        rd_chk("pair2 low", pttc_pkg::IDX_P2_LO, 32'h0);
        rd_chk("pair2 high", pttc_pkg::IDX_P2_HI, 32'h0);
        rd_chk("pair3 low", pttc_pkg::IDX_P3_LO, 32'h0);
        rd_chk("pair3 high", pttc_pkg::IDX_P3_HI, 32'h0);
        rd_chk("control", pttc_pkg::IDX_CTRL, pttc_pkg::CTRL_RST);
        axi_rd(16'h0000);
        chk("unmapped read", {30'h0, r}, {30'h0, pttc_pkg::RESP_SLVERR});
        axi_wr(16'h0000, 32'hFFFF_FFFF);
        chk("unmapped write", {30'h0, r}, {30'h0, pttc_pkg::RESP_SLVERR});
        axi_wr(pttc_pkg::IDX_CTRL, 32'h0000_1000);
        pulse(4, 5);
        rd_chk("pair3 low count", pttc_pkg::IDX_P3_LO, 32'h5);
        rd_chk("pair3 high idle", pttc_pkg::IDX_P3_HI, 32'h0);
        axi_wr(pttc_pkg::IDX_P3_LO, 32'hFFFF_FFFF);
        rd_chk("pair3 low cleared", pttc_pkg::IDX_P3_LO, 32'h0);
        // fast system clock, slow timer clock: read twice, the two reads must agree
        axi_wr(pttc_pkg::IDX_CTRL, 32'h0000_1008);
        pulse(4, 3);
        axi_rd(pttc_pkg::IDX_P3_LO);
        prev = d;
        rd_chk("pair3 low re-read", pttc_pkg::IDX_P3_LO, prev);
        chk("pair3 low settled", prev, 32'h3);
        for (int f = 0; f < 2; f++) begin
            for (int cs = 0; cs < 8; cs++) begin
                axi_wr(pttc_pkg::IDX_CLKSEL, 32'(cs) << 12);
                axi_wr(pttc_pkg::IDX_CTRL, 32'h0000_1000 | (32'(f) << 3));
                single = f ? (cs == 1) : (cs == 0);
                usable = f ? (cs != 7) : (cs == 0);
                axi_rd(pttc_pkg::IDX_STATUS);
                chk("single read valid", {31'h0, d[4]}, {31'h0, single});
                chk("read usable", {31'h0, d[12]}, {31'h0, usable});
            end
        end
        rd_chk("clock select", pttc_pkg::IDX_CLKSEL, 32'h0000_7000);
        // stopped timer reads always valid
        axi_wr(pttc_pkg::IDX_CTRL, 32'h0000_0008);
        axi_rd(pttc_pkg::IDX_STATUS);
        chk("stopped status", d & 32'h0000_1010, 32'h0000_1010);
        // pair2 joined, high counts low wraps; low read first
        axi_wr(pttc_pkg::IDX_CTRL, 32'h0000_0402);
        pulse(2, 259);
        rd_chk("pair2 low 16", pttc_pkg::IDX_P2_LO, 32'h3);
        rd_chk("pair2 high 16", pttc_pkg::IDX_P2_HI, 32'h1);
        pulse(2, 256);
        rd_chk("pair2 high latched", pttc_pkg::IDX_P2_HI, 32'h1);
        rd_chk("pair2 low again", pttc_pkg::IDX_P2_LO, 32'h3);
        rd_chk("pair2 high relatched", pttc_pkg::IDX_P2_HI, 32'h2);
        chk("paired low no event", 32'(ovf_cnt[2]), 32'h0);
        // write to high clears both halves
        axi_wr(pttc_pkg::IDX_CTRL, 32'h0000_0002);
        axi_wr(pttc_pkg::IDX_P2_HI, 32'h0000_00A5);
        rd_chk("pair2 low joint clear", pttc_pkg::IDX_P2_LO, 32'h0);
        rd_chk("pair2 high joint clear", pttc_pkg::IDX_P2_HI, 32'h0);
        axi_wr(pttc_pkg::IDX_CTRL, 32'h0000_0100);
        pulse(0, 256);
        rd_chk("pair1 low wrapped", pttc_pkg::IDX_P1_LO, 32'h0);
        chk("pair1 low wrap event", 32'(ovf_cnt[0]), 32'h1);
        final_report();
    end
endmodule // pttc_top_test
